// File: tfc_consts.vh
// Purpose: Named constants for the timer flag and asynchronous clock control block.
// Assumes: Offsets are register indices; the APB byte address is four times the index.
// Notes: Definitions only.
`ifndef TFC_CONSTS_VH
`define TFC_CONSTS_VH
`define TFC_IDX_FLAGS 8'h37
`define TFC_IDX_PSC_CTL 8'h43
`define TFC_IDX_ASYNC 8'hb6
`define TFC_IDX_MASK 8'h70
`define TFC_IDX_CNT 8'hb2
`define TFC_IDX_CMPA 8'hb3
`define TFC_IDX_CMPB 8'hb4
`define TFC_IDX_CTLA 8'hb0
`define TFC_IDX_CTLB 8'hb1
`define TFC_IDX_GIE 8'hc0
`define TFC_IDX_VEC 8'hc1
`define TFC_BIT_OVF 0
`define TFC_BIT_CMPA 1
`define TFC_BIT_CMPB 2
`define TFC_BIT_EXT_CLK 6
`define TFC_BIT_ASEL 5
`define TFC_BIT_PSR 1
`define TFC_BIT_HOLD 7
`define TFC_UB_CNT 4
`define TFC_UB_CMPA 3
`define TFC_UB_CMPB 2
`define TFC_UB_CTLA 1
`define TFC_UB_CTLB 0
`define TFC_RST_BYTE 8'h00
`define TFC_BOTTOM 8'h00
`define TFC_TOP 8'hff
`define TFC_WGM_PC 2'h1
`define TFC_ZERO32 32'h0000_0000
`endif

// File: tfc_timer_core.v
// Purpose: Clocked timer counter with prescaler, compare and event pulses.
// Assumes: Runs on pclk; tick_en is a one-cycle timer clock enable.
// Notes: Phase correct mode reverses at top and bottom.
`timescale 1ns/10ps
`include "tfc_consts.vh"
module tfc_timer_core (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire tick_en,
  input wire pre_clr,
  input wire [2:0] clk_sel,
  input wire phase_correct,
  input wire cnt_wr,
  input wire [7:0] cnt_wdata,
  input wire [7:0] cmp_a,
  input wire [7:0] cmp_b,
  // Status
  output reg [7:0] cnt_q,
  output reg ovf_ev,
  output reg cmpa_ev,
  output reg cmpb_ev
);
  reg [9:0] pre_q;
  reg down_q;
  reg block_q;
  reg step;
  wire [9:0] pre_d;
  assign pre_d = pre_q + 10'h001;
  always @*
  begin
    case (clk_sel)
      3'h1: step = tick_en;
      3'h2: step = tick_en & (pre_q[2:0] == 3'h7);
      3'h3: step = tick_en & (pre_q[4:0] == 5'h1f);
      3'h4: step = tick_en & (pre_q[5:0] == 6'h3f);
      3'h5: step = tick_en & (pre_q[6:0] == 7'h7f);
      3'h6: step = tick_en & (pre_q[7:0] == 8'hff);
      3'h7: step = tick_en & (pre_q == 10'h3ff);
      default: step = 1'b0;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 10'h000;
      cnt_q <= `TFC_RST_BYTE;
      down_q <= 1'b0;
      block_q <= 1'b0;
      ovf_ev <= 1'b0;
      cmpa_ev <= 1'b0;
      cmpb_ev <= 1'b0;
    end
    else
    begin
      ovf_ev <= 1'b0;
      cmpa_ev <= 1'b0;
      cmpb_ev <= 1'b0;
      if (pre_clr)
        pre_q <= 10'h000;
      else if (tick_en)
        pre_q <= pre_d;
      if (cnt_wr)
      begin
        cnt_q <= cnt_wdata;
        block_q <= 1'b1;
      end
      else if (step)
      begin
        block_q <= 1'b0;
        cmpa_ev <= ~block_q & (cnt_q == cmp_a);
        cmpb_ev <= ~block_q & (cnt_q == cmp_b);
        if (phase_correct)
        begin
          if (down_q && cnt_q == `TFC_BOTTOM)
          begin
            down_q <= 1'b0;
            ovf_ev <= 1'b1;
            cnt_q <= cnt_q + 8'h01;
          end
          else if (!down_q && cnt_q == `TFC_TOP)
          begin
            down_q <= 1'b1;
            cnt_q <= cnt_q - 8'h01;
          end
          else if (down_q)
            cnt_q <= cnt_q - 8'h01;
          else
            cnt_q <= cnt_q + 8'h01;
        end
        else
        begin
          down_q <= 1'b0;
          ovf_ev <= (cnt_q == `TFC_TOP);
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // tfc_timer_core

// File: tfc_top.v
// Purpose: Flag, interrupt and asynchronous clock control for an 8-bit two-channel timer.
// Assumes: APB slave on pclk; the low speed clock pin is sampled through three flip-flops.
// Notes: Busy bits track a handoff delay into the slow domain of three slow ticks.
// How it works
// - Compare flags B (bit 2) and A (bit 1) set when counter equals compare.
// - Overflow flag, bit 0, sets when counter overflows.
// - Each event flag clears when the processor vectors to its handler.
// - Writing one clears an event flag; zero leaves it.
// - Interrupt needs global enable, event enable and event flag all one.
// - In up/down PWM, overflow flag sets on reversal at bottom.
// - Status register top bit reads zero.
// - External clock bit enables input buffer when select bit is one; crystal runs only when it is zero.
// - Select bit zero uses I/O clock; one uses the oscillator pin.
// - Switching clock source may corrupt counter, compare and control registers.
// - Asynchronous writes set update-busy bits 4..0 until transferred.
// - Async reads: counter gives live value; others give temporary storage.
// - Writing one to prescaler reset bit 1 resets prescaler, then self-clears.
// - In async mode the reset bit stays one until done there.
// - While sync hold bit 7 is set, the reset bit is not cleared.
// - Mask register bits 0,1,2 enable overflow, compare A, compare B.
// - Counter write suppresses the compare match on the next timer clock.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "tfc_consts.vh"
module tfc_top (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Oscillator pin and analog controls
  input wire osc_input_pin,
  output wire ext_buf_en,
  output wire xtal_osc_en,
  // Interrupt vectoring
  input wire [2:0] vector_ack,
  output wire [2:0] irq_req,
  // Timer outputs
  output wire [7:0] counter_value
);
  reg [7:0] flags_q;
  reg [2:0] irq_mask_q;
  reg gie_q;
  reg ext_clock_input_enable_q;
  reg async_clock_select_q;
  reg sync_hold_mode_q;
  reg async_prescaler_reset_q;
  // Software-visible copies held while an asynchronous handoff is pending.
  reg [7:0] tmp_cmpa_q;
  reg [7:0] tmp_cmpb_q;
  reg [7:0] tmp_ctla_q;
  reg [7:0] tmp_ctlb_q;
  reg [7:0] tmp_cnt_q;
  // Working copies that the timer core actually uses.
  reg [7:0] compare_a_value_q;
  reg [7:0] compare_b_value_q;
  reg [7:0] control_a_q;
  reg [7:0] control_b_q;
  reg [4:0] busy_q;
  reg [1:0] slow_tick_q;
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg [31:0] rdata_d;

  wire acc;
  wire wr;
  wire [7:0] idx;
  wire [7:0] wb;
  wire flag_wr;
  wire psc_wr;
  wire async_wr;
  wire slow_edge;
  wire tick_en;
  wire cnt_load;
  wire ovf_ev;
  wire cmpa_ev;
  wire cmpb_ev;
  wire [2:0] ev;
  wire [2:0] flags_d;
  wire [7:0] async_rd;

  // Every access completes in one cycle, so the bus never stalls or errors.
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign idx = paddr[9:2];
  assign wb = pwdata[7:0];
  assign flag_wr = wr & (idx == `TFC_IDX_FLAGS);
  assign psc_wr = wr & (idx == `TFC_IDX_PSC_CTL);
  assign async_wr = wr & (idx == `TFC_IDX_ASYNC);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // The oscillator pin is sampled; the second and third stages feed the edge detector.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_input_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // A rising edge of the synchronised pin is one slow timer clock.
  assign slow_edge = osc_s2_q & ~osc_s3_q;
  // The slow clock only acts as a step enable, so the whole block stays on pclk.
  assign tick_en = async_clock_select_q ? slow_edge : 1'b1;
  assign ext_buf_en = ext_clock_input_enable_q & async_clock_select_q;
  assign xtal_osc_en = async_clock_select_q & ~ext_clock_input_enable_q;
  // A counter write in async mode lands once the busy bit drops.
  assign cnt_load = async_clock_select_q ?
    (busy_q[`TFC_UB_CNT] & slow_edge & slow_tick_q[1]) :
    (wr & idx == `TFC_IDX_CNT);

  tfc_timer_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .tick_en(tick_en),
    .pre_clr(async_prescaler_reset_q),
    .clk_sel(control_b_q[2:0]),
    .phase_correct(control_a_q[1:0] == `TFC_WGM_PC),
    .cnt_wr(cnt_load),
    .cnt_wdata(async_clock_select_q ? tmp_cnt_q : wb),
    .cmp_a(compare_a_value_q),
    .cmp_b(compare_b_value_q),
    .cnt_q(counter_value),
    .ovf_ev(ovf_ev),
    .cmpa_ev(cmpa_ev),
    .cmpb_ev(cmpb_ev)
  );

  assign ev = {cmpb_ev, cmpa_ev, ovf_ev};
  // Event flags: a set in the same cycle as a clear wins, so no event is lost to a
  // late acknowledge or a software clear.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_flag
      assign flags_d[gi] = ev[gi] |
        (flags_q[gi] & ~vector_ack[gi] & ~(flag_wr & wb[gi]));
    end
  endgenerate
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= `TFC_RST_BYTE;
    else
    begin
      flags_q[7:3] <= 5'h00;
      flags_q[2:0] <= flags_d;
    end
  end
  assign irq_req = {3{gie_q}} & irq_mask_q & flags_q[2:0];

  // Control registers and the temporary storage path.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_q <= 3'h0;
      gie_q <= 1'b0;
      ext_clock_input_enable_q <= 1'b0;
      async_clock_select_q <= 1'b0;
      sync_hold_mode_q <= 1'b0;
      async_prescaler_reset_q <= 1'b0;
      tmp_cmpa_q <= `TFC_RST_BYTE;
      tmp_cmpb_q <= `TFC_RST_BYTE;
      tmp_ctla_q <= `TFC_RST_BYTE;
      tmp_ctlb_q <= `TFC_RST_BYTE;
      tmp_cnt_q <= `TFC_RST_BYTE;
      compare_a_value_q <= `TFC_RST_BYTE;
      compare_b_value_q <= `TFC_RST_BYTE;
      control_a_q <= `TFC_RST_BYTE;
      control_b_q <= `TFC_RST_BYTE;
      busy_q <= 5'h00;
      slow_tick_q <= 2'h0;
    end
    else
    begin
      if (wr && idx == `TFC_IDX_MASK)
        irq_mask_q <= wb[2:0];
      if (wr && idx == `TFC_IDX_GIE)
        gie_q <= wb[0];
      if (async_wr)
      begin
        ext_clock_input_enable_q <= wb[`TFC_BIT_EXT_CLK];
        // Switching source leaves timer registers as they are; contents not guaranteed.
        async_clock_select_q <= wb[`TFC_BIT_ASEL];
        busy_q <= 5'h00;
      end
      // Busy window: count two slow edges after the first pending write, then transfer on the third.
      if (|busy_q && slow_edge)
        slow_tick_q <= slow_tick_q + 2'h1;
      if (async_clock_select_q && slow_edge && slow_tick_q[1])
      begin
        if (busy_q[`TFC_UB_CMPA])
          compare_a_value_q <= tmp_cmpa_q;
        if (busy_q[`TFC_UB_CMPB])
          compare_b_value_q <= tmp_cmpb_q;
        if (busy_q[`TFC_UB_CTLA])
          control_a_q <= tmp_ctla_q;
        if (busy_q[`TFC_UB_CTLB])
          control_b_q <= tmp_ctlb_q;
        busy_q <= 5'h00;
        slow_tick_q <= 2'h0;
      end
      if (wr && idx == `TFC_IDX_CMPA)
      begin
        tmp_cmpa_q <= wb;
        if (async_clock_select_q)
          busy_q[`TFC_UB_CMPA] <= 1'b1;
        else
          compare_a_value_q <= wb;
      end
      if (wr && idx == `TFC_IDX_CMPB)
      begin
        tmp_cmpb_q <= wb;
        if (async_clock_select_q)
          busy_q[`TFC_UB_CMPB] <= 1'b1;
        else
          compare_b_value_q <= wb;
      end
      if (wr && idx == `TFC_IDX_CTLA)
      begin
        tmp_ctla_q <= wb;
        if (async_clock_select_q)
          busy_q[`TFC_UB_CTLA] <= 1'b1;
        else
          control_a_q <= wb;
      end
      if (wr && idx == `TFC_IDX_CTLB)
      begin
        tmp_ctlb_q <= wb;
        if (async_clock_select_q)
          busy_q[`TFC_UB_CTLB] <= 1'b1;
        else
          control_b_q <= wb;
      end
      if (wr && idx == `TFC_IDX_CNT)
      begin
        tmp_cnt_q <= wb;
        if (async_clock_select_q)
          busy_q[`TFC_UB_CNT] <= 1'b1;
      end
      // The hold bit keeps the prescaler in reset so several timers can start together.
      if (psc_wr)
      begin
        sync_hold_mode_q <= wb[`TFC_BIT_HOLD];
        async_prescaler_reset_q <= wb[`TFC_BIT_PSR];
      end
      else if (async_prescaler_reset_q && !sync_hold_mode_q)
      begin
        // In async mode the clear waits for a slow edge to confirm the reset.
        if (!async_clock_select_q || slow_edge)
          async_prescaler_reset_q <= 1'b0;
      end
    end
  end

  // The reserved top bit of the status byte is tied low.
  assign async_rd = {1'b0, ext_clock_input_enable_q, async_clock_select_q, busy_q};
  always @*
  begin
    rdata_d = `TFC_ZERO32;
    case (idx)
      `TFC_IDX_FLAGS: rdata_d[7:0] = flags_q;
      `TFC_IDX_PSC_CTL: rdata_d[7:0] = {sync_hold_mode_q, 5'h00, async_prescaler_reset_q, 1'b0};
      `TFC_IDX_ASYNC: rdata_d[7:0] = async_rd;
      `TFC_IDX_MASK: rdata_d[2:0] = irq_mask_q;
      `TFC_IDX_GIE: rdata_d[0] = gie_q;
      `TFC_IDX_CNT: rdata_d[7:0] = counter_value;
      `TFC_IDX_CMPA: rdata_d[7:0] = tmp_cmpa_q;
      `TFC_IDX_CMPB: rdata_d[7:0] = tmp_cmpb_q;
      `TFC_IDX_CTLA: rdata_d[7:0] = tmp_ctla_q;
      `TFC_IDX_CTLB: rdata_d[7:0] = tmp_ctlb_q;
      default: rdata_d = `TFC_ZERO32;
    endcase
  end

  // Read data is captured in the setup cycle, so it already stands in the access phase.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `TFC_ZERO32;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end
endmodule // tfc_top

// File: tfc_props.sv
// Purpose: Port-level assertions for tfc_top.
// Assumes: Byte address is four times the register index.
// Notes: Reads are judged one edge after the setup cycle that latches them.
`timescale 1ns/10ps
`include "tfc_consts.vh"
module tfc_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire osc_input_pin,
  input wire ext_buf_en,
  input wire xtal_osc_en,
  input wire [2:0] vector_ack,
  input wire [2:0] irq_req,
  input wire [7:0] counter_value
);
  wire rd_setup = psel && !penable && !pwrite;
  wire wr_take = psel && penable && pwrite;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_answer_a: assert property (pready && !pslverr) else $error("bus answer wrong");
  osc_excl_a: assert property (!(ext_buf_en && xtal_osc_en))
    else $error("buffer and crystal both on");
  buf_cause_a: assert property ($rose(ext_buf_en) |->
    $past(wr_take && paddr[9:2] == `TFC_IDX_ASYNC)) else $error("buffer rose alone");
  async_top_a: assert property (rd_setup && paddr[9:2] == `TFC_IDX_ASYNC |=>
    prdata[31:7] == 25'h0) else $error("status top bit set");
  flag_rsvd_a: assert property (rd_setup && paddr[9:2] == `TFC_IDX_FLAGS |=>
    prdata[31:3] == 29'h0) else $error("flag spare bits set");
  gtc_rsvd_a: assert property (rd_setup && paddr[9:2] == `TFC_IDX_PSC_CTL |=>
    prdata[31:8] == 24'h0 && prdata[6:2] == 5'h0) else $error("prescaler spare bits set");
  unmapped_zero_a: assert property (rd_setup && paddr[9:2] < 8'h37 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  ack_clear_a: assert property (vector_ack[0] |=> !irq_req[0])
    else $error("vectoring left request");
endmodule // tfc_props
bind tfc_top tfc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_input_pin(osc_input_pin),
  .ext_buf_en(ext_buf_en), .xtal_osc_en(xtal_osc_en), .vector_ack(vector_ack),
  .irq_req(irq_req), .counter_value(counter_value));

// File: tb_tfc_top.sv
// Purpose: Self-checking bench for tfc_top.
// Assumes: Clock select 1 steps the counter every pclk.
// Notes: The slow pin toggles every 8 pclk so handoffs finish well inside the poll bound.
`timescale 1ns/10ps
`include "tfc_consts.vh"
module tb_tfc_top;
  reg pclk, presetn, psel, penable, pwrite, osc;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [2:0] vack;
  wire [31:0] prdata;
  wire pready, pslverr, ebuf, xosc;
  wire [2:0] irq;
  wire [7:0] cnt;
  integer n_fail, checks;
  tfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_input_pin(osc), .ext_buf_en(ebuf), .xtal_osc_en(xosc),
    .vector_ack(vack), .irq_req(irq), .counter_value(cnt));
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  initial
  forever
  begin
    repeat (8) @(posedge pclk);
    osc <= ~osc;
  end
  task print_verdict;
  begin
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // The short settle delay lets the access edge's updates land before anything is judged.
  task apb(input w, input [7:0] idx, input [31:0] d);
    integer n;
  begin
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (n == 20)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  endtask
  task wt(input [7:0] idx, input [31:0] m, input [31:0] v);
    integer n;
  begin
    n = 0;
    apb(0, idx, 0);
    while ((rd & m) !== v && n < 700)
    begin
      n = n + 1;
      apb(0, idx, 0);
    end
    if (n == 700)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  endtask
  task t_reset;
  begin
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd, 0);
    apb(0, `TFC_IDX_PSC_CTL, 0);
    chk(rd, 0);
    apb(0, `TFC_IDX_ASYNC, 0);
    chk(rd, 0);
    apb(0, 8'h10, 0);
    chk(rd, 0);
  end
  endtask
  task t_flags;
  begin
    apb(1, `TFC_IDX_MASK, 7);
    apb(1, `TFC_IDX_GIE, 1);
    apb(1, `TFC_IDX_CMPA, 32'h20);
    apb(1, `TFC_IDX_CMPB, 32'h40);
    apb(1, `TFC_IDX_CTLB, 1);
    wt(`TFC_IDX_FLAGS, 2, 2);
    chk(irq[1], 1);
    wt(`TFC_IDX_FLAGS, 5, 5);
    apb(1, `TFC_IDX_CTLB, 0);
    apb(1, `TFC_IDX_FLAGS, 0);
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd, 7);
    chk(irq, 7);
    @(posedge pclk);
    vack <= 3'b001;
    @(posedge pclk);
    vack <= 3'b000;
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd, 6);
    apb(1, `TFC_IDX_FLAGS, 2);
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd, 4);
    apb(1, `TFC_IDX_MASK, 3);
    chk(irq, 0);
    apb(1, `TFC_IDX_MASK, 4);
    chk(irq, 4);
    apb(1, `TFC_IDX_GIE, 0);
    chk(irq, 0);
  end
  endtask
  task t_pwm;
  begin
    apb(1, `TFC_IDX_FLAGS, 7);
    apb(1, `TFC_IDX_CTLA, 1);
    apb(1, `TFC_IDX_CNT, 32'hfe);
    apb(1, `TFC_IDX_CTLB, 1);
    // Just past the top value: up/down counting must not have flagged an overflow.
    repeat (10) @(posedge pclk);
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd & 1, 0);
    wt(`TFC_IDX_FLAGS, 1, 1);
    apb(1, `TFC_IDX_CTLB, 0);
    apb(1, `TFC_IDX_CTLA, 0);
  end
  endtask
  task t_async;
  begin
    apb(1, `TFC_IDX_ASYNC, 32'h40);
    chk({ebuf, xosc}, 0);
    apb(1, `TFC_IDX_ASYNC, 32'h60);
    chk({ebuf, xosc}, 2);
    apb(1, `TFC_IDX_ASYNC, 32'h20);
    chk({ebuf, xosc}, 1);
    apb(1, `TFC_IDX_CNT, 32'h33);
    apb(0, `TFC_IDX_ASYNC, 0);
    chk(rd, 32'h30);
    apb(1, `TFC_IDX_CMPA, 32'h77);
    apb(0, `TFC_IDX_CMPA, 0);
    chk(rd, 32'h77);
    wt(`TFC_IDX_ASYNC, 32'h1f, 0);
    apb(0, `TFC_IDX_CNT, 0);
    chk(rd, 32'h33);
    apb(1, `TFC_IDX_PSC_CTL, 32'h82);
    repeat (40) @(posedge pclk);
    apb(0, `TFC_IDX_PSC_CTL, 0);
    chk(rd, 32'h82);
    apb(1, `TFC_IDX_PSC_CTL, 0);
    apb(1, `TFC_IDX_PSC_CTL, 2);
    wt(`TFC_IDX_PSC_CTL, 2, 0);
  end
  endtask
  task t_sync;
  begin
    apb(1, `TFC_IDX_ASYNC, 0);
    apb(1, `TFC_IDX_CNT, 32'h44);
    apb(0, `TFC_IDX_ASYNC, 0);
    chk(rd, 0);
    chk(cnt, 32'h44);
    apb(1, `TFC_IDX_PSC_CTL, 2);
    @(posedge pclk);
    apb(0, `TFC_IDX_PSC_CTL, 0);
    chk(rd, 0);
    // Load the running counter onto compare A: the match on the next step is dropped.
    apb(1, `TFC_IDX_CMPA, 32'h77);
    apb(1, `TFC_IDX_FLAGS, 7);
    apb(1, `TFC_IDX_CTLB, 1);
    apb(1, `TFC_IDX_CNT, 32'h77);
    repeat (3) @(posedge pclk);
    apb(0, `TFC_IDX_FLAGS, 0);
    chk(rd, 0);
    apb(1, `TFC_IDX_CTLB, 0);
  end
  endtask
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    osc = 0;
    vack = 0;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_flags;
    t_pwm;
    t_async;
    t_sync;
    print_verdict;
  end
endmodule // tb_tfc_top
